// >>> logic/isc_ctrl.sv
// Purpose: Interrupt flags, entry and return stacking, and sleep control.
// Assumes: The core raises commands only while o_busy is low.
// Notes:   This logic runs on the always-on clock; o_sys_clk_en gates the core.
//
// Overview of operation
// - Eight request sources feed the flag register.
// - Each source has its own enable bit.
// - Hardware sets flags; software clears by writing.
// - Edge select picks rising, falling or both.
// - Global enable gates all lines; instructions toggle.
// - Save and restore working and flag registers.
// - Entry writes program counter at stack pointer.
// - Entry then adds two to stack pointer.
// - Entry clears global enable automatically.
// - After entry fetch from address 0x010.
// - Flags set even when source enable is off.
// - Return pops counter, stack pointer minus two.
// - Return sets global enable again.
// - Light sleep stops system clock and program memory.
// - Timers on system clock stop in light sleep.
// - Light sleep ends on pin toggle or timer.
// - Comparator wakes only with both enables set.
// - Deep sleep stops oscillators and program memory.
// - Deep sleep ends on pin toggle; continue.
// - Resume about 3000 slow oscillator periods later.
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl #(
   parameter int unsigned WAKE_CYCLES = isc_pkg::WAKE_CYCLES_DFLT
) (
   // Clock, reset, enable.
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_clk_en,
   // Register port.
   input  wire logic [3:0]            i_addr,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [7:0]            o_rdata,
   // Core side.
   input  wire logic                  i_boundary,
   input  wire isc_pkg::isc_cmd_s     i_cmd,
   input  wire logic [15:0]           i_pc,
   input  wire logic [7:0]            i_work_reg,
   input  wire logic [7:0]            i_flag_reg,
   output logic                       o_busy,
   output logic                       o_pc_load,
   output logic                       o_af_load,
   output logic      [15:0]           o_ld_value,
   output logic                       o_gie,
   // Stack memory port.
   output logic                       o_mem_we,
   output logic                       o_mem_re,
   output logic      [7:0]            o_mem_addr,
   output logic      [7:0]            o_mem_wdata,
   input  wire logic [7:0]            i_mem_rdata,
   // Request sources and wake inputs.
   input  wire logic [7:0]            i_irq_src,
   input  wire logic [7:0]            i_pin,
   input  wire logic [7:0]            i_pin_is_input,
   input  wire logic [7:0]            i_digital_input_enable,
   input  wire isc_pkg::isc_tmr_s     i_tmr,
   input  wire logic                  i_cmp_en,
   input  wire logic                  i_cmp_wake_en,
   input  wire logic                  i_cmp_event,
   // Power control.
   output logic                       o_sys_clk_en,
   output logic                       o_osc_run,
   output logic                       o_otp_on,
   output logic      [2:0]            o_tmr_run
);
   localparam logic [isc_pkg::WCNT_W-1:0] WCNT_LAST =
      isc_pkg::WCNT_W'(WAKE_CYCLES - 1);
   localparam logic [isc_pkg::WCNT_W-1:0] WCNT_ONE =
      isc_pkg::WCNT_W'(1);

   isc_pkg::isc_ctl_s q;
   isc_pkg::isc_ctl_s n;
   logic [7:0] src;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] set_ev;
   logic [7:0] clr;
   logic [7:0] stat;
   logic [7:0] tog;
   logic       take;
   logic       wake_l;
   logic       wake_d;
   logic [1:0] esel;

   always_comb begin
      n = q;
      src = '0;
      rise = '0;
      fall = '0;
      set_ev = '0;
      clr = '0;
      stat = '0;
      esel = isc_pkg::EDGE_BOTH;
      n.mem_we = 1'b0;
      n.mem_re = 1'b0;
      n.pc_load = 1'b0;
      n.af_load = 1'b0;
      n.rdata = 8'h00;

      // External pins cross into this clock through two flops.
      n.ext_s1 = i_irq_src[isc_pkg::EXT_N-1:0];
      n.ext_s2 = q.ext_s1;
      n.pin_s1 = i_pin;
      n.pin_s2 = q.pin_s1;
      n.pin_prev = q.pin_s2;
      tog = q.pin_s2 ^ q.pin_prev;

      // Eight sources; flags set regardless of enables.
      src = {i_irq_src[7:isc_pkg::EXT_N], q.ext_s2};
      n.src_prev = src;
      rise = src & ~q.src_prev;
      fall = ~src & q.src_prev;
      for (int i = 0; i < isc_pkg::N_SRC; i++) begin
         esel = q.edges[2*i +: 2];
         set_ev[i] = (rise[i] && esel != isc_pkg::EDGE_FALL)
                  || (fall[i] && esel != isc_pkg::EDGE_RISE);
      end

      // Register writes. Writing 0 to a flag clears it; a new event wins.
      if (i_wr) begin
         case (i_addr)
            isc_pkg::A_IRQ_EN: n.en = i_wdata;
            isc_pkg::A_IRQ_FLAG: clr = ~i_wdata;
            isc_pkg::A_EDGE_LO: n.edges[7:0] = i_wdata;
            isc_pkg::A_EDGE_HI: n.edges[15:8] = i_wdata;
            isc_pkg::A_STACK: n.sp = i_wdata;
            default: n.en = q.en;
         endcase
      end
      n.flags = (q.flags & ~clr) | set_ev;

      stat[isc_pkg::ST_GIE_BIT] = q.gie;
      stat[isc_pkg::ST_BUSY_BIT] = q.busy;
      if (i_rd) begin
         case (i_addr)
            isc_pkg::A_IRQ_EN: n.rdata = q.en;
            isc_pkg::A_IRQ_FLAG: n.rdata = q.flags;
            isc_pkg::A_EDGE_LO: n.rdata = q.edges[7:0];
            isc_pkg::A_EDGE_HI: n.rdata = q.edges[15:8];
            isc_pkg::A_STACK: n.rdata = q.sp;
            isc_pkg::A_STATUS: n.rdata = stat;
            default: n.rdata = 8'h00;
         endcase
      end

      take = i_boundary && q.gie && (|(q.flags & q.en));
      wake_l = (|(tog & i_pin_is_input & i_digital_input_enable))
            || (|(i_tmr.match & ~i_tmr.clk_is_sys))
            || (i_cmp_event && i_cmp_en && i_cmp_wake_en);
      wake_d = |(tog & i_digital_input_enable);

      case (q.st)
         isc_pkg::ST_RUN: begin
            if (i_cmd.gie_on) begin
               n.gie = 1'b1;
            end
            if (i_cmd.gie_off) begin
               n.gie = 1'b0;
            end
            if (i_cmd.reti || i_cmd.pop_af) begin
               // The stack pointer names the slot above the newest entry.
               n.sp = q.sp - isc_pkg::SP_STEP;
               n.mem_re = 1'b1;
               n.mem_addr = q.sp - isc_pkg::SP_STEP;
               n.pop_pc = i_cmd.reti;
               n.busy = 1'b1;
               n.st = isc_pkg::ST_POP1;
            end else if (i_cmd.push_af) begin
               n.mem_we = 1'b1;
               n.mem_addr = q.sp;
               n.mem_wdata = i_work_reg;
               n.hold = {i_flag_reg, i_work_reg};
               n.busy = 1'b1;
               n.st = isc_pkg::ST_PAF;
            end else if (i_cmd.sleep_deep) begin
               n.st = isc_pkg::ST_SLPD;
            end else if (i_cmd.sleep_light) begin
               n.st = isc_pkg::ST_SLPL;
            end else if (take && !i_cmd.gie_off) begin
               n.mem_we = 1'b1;
               n.mem_addr = q.sp;
               n.mem_wdata = i_pc[7:0];
               n.hold = i_pc;
               n.gie = 1'b0;
               n.busy = 1'b1;
               n.st = isc_pkg::ST_ENT;
            end
         end
         isc_pkg::ST_ENT, isc_pkg::ST_PAF: begin
            n.mem_we = 1'b1;
            n.mem_addr = q.sp + isc_pkg::SP_HI_OFS;
            n.mem_wdata = q.hold[15:8];
            n.sp = q.sp + isc_pkg::SP_STEP;
            if (q.st == isc_pkg::ST_ENT) begin
               n.pc_load = 1'b1;
               n.ld_value = isc_pkg::IRQ_VECTOR;
            end
            n.busy = 1'b0;
            n.st = isc_pkg::ST_RUN;
         end
         isc_pkg::ST_POP1: begin
            n.mem_re = 1'b1;
            n.mem_addr = q.sp + isc_pkg::SP_HI_OFS;
            n.st = isc_pkg::ST_POP2;
         end
         isc_pkg::ST_POP2: begin
            n.hold[7:0] = i_mem_rdata;
            n.st = isc_pkg::ST_POP3;
         end
         isc_pkg::ST_POP3: begin
            n.ld_value = {i_mem_rdata, q.hold[7:0]};
            if (q.pop_pc) begin
               n.pc_load = 1'b1;
               n.gie = 1'b1;
            end else begin
               n.af_load = 1'b1;
            end
            n.busy = 1'b0;
            n.st = isc_pkg::ST_RUN;
         end
         isc_pkg::ST_SLPL: begin
            if (wake_l) begin
               n.wcnt = '0;
               n.st = isc_pkg::ST_WAKE;
            end
         end
         isc_pkg::ST_SLPD: begin
            if (wake_d) begin
               n.wcnt = '0;
               n.st = isc_pkg::ST_WAKE;
            end
         end
         isc_pkg::ST_WAKE: begin
            // Resume needs no PC load: the core continues after the sleep.
            n.wcnt = q.wcnt + WCNT_ONE;
            if (q.wcnt == WCNT_LAST) begin
               n.st = isc_pkg::ST_RUN;
            end
         end
         default: n.st = isc_pkg::ST_RUN;
      endcase

      // Power outputs follow the state being entered.
      case (n.st)
         isc_pkg::ST_SLPL: begin
            n.sys_clk_en = 1'b0;
            n.osc_run = 1'b1;
            n.otp_on = 1'b0;
            n.tmr_run = ~i_tmr.clk_is_sys & i_tmr.osc_on;
         end
         isc_pkg::ST_SLPD: begin
            n.sys_clk_en = 1'b0;
            n.osc_run = 1'b0;
            n.otp_on = 1'b0;
            n.tmr_run = '0;
         end
         isc_pkg::ST_WAKE: begin
            n.sys_clk_en = 1'b0;
            n.osc_run = 1'b1;
            n.otp_on = 1'b1;
            n.tmr_run = ~i_tmr.clk_is_sys & i_tmr.osc_on;
         end
         default: begin
            n.sys_clk_en = 1'b1;
            n.osc_run = 1'b1;
            n.otp_on = 1'b1;
            n.tmr_run = '1;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= isc_pkg::CTL_RST;
      end else if (i_clk_en) begin
         q <= n;
      end
   end

   assign o_rdata = q.rdata;
   assign o_busy = q.busy;
   assign o_pc_load = q.pc_load;
   assign o_af_load = q.af_load;
   assign o_ld_value = q.ld_value;
   assign o_gie = q.gie;
   assign o_mem_we = q.mem_we;
   assign o_mem_re = q.mem_re;
   assign o_mem_addr = q.mem_addr;
   assign o_mem_wdata = q.mem_wdata;
   assign o_sys_clk_en = q.sys_clk_en;
   assign o_osc_run = q.osc_run;
   assign o_otp_on = q.otp_on;
   assign o_tmr_run = q.tmr_run;

   // Checks hold while the clock enable stays high.
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn || !i_clk_en);

   take_gated_a: assert property (
      (q.st == isc_pkg::ST_RUN && n.st == isc_pkg::ST_ENT)
      |-> (q.gie && (|(q.flags & q.en)) && i_boundary))
      else $error("entry without enabled pending request");
   push_pc_a: assert property (
      (q.st == isc_pkg::ST_RUN && n.st == isc_pkg::ST_ENT)
      |=> (o_mem_we && o_mem_addr == $past(q.sp) && o_mem_wdata == $past(i_pc[7:0]))
      ##1 (o_mem_we && o_mem_wdata == $past(i_pc[15:8], 2)))
      else $error("program counter not pushed");
   sp_up_two_a: assert property (
      q.st == isc_pkg::ST_ENT |=> q.sp == $past(q.sp) + isc_pkg::SP_STEP)
      else $error("stack pointer not raised by two");
   gie_entry_a: assert property (
      q.st == isc_pkg::ST_ENT |-> !o_gie ##1 !o_gie)
      else $error("global enable not cleared on entry");
   vector_load_a: assert property (
      q.st == isc_pkg::ST_ENT |=> o_pc_load && o_ld_value == isc_pkg::IRQ_VECTOR)
      else $error("vector not loaded");
   flag_sets_a: assert property (
      (|set_ev) |=> ((q.flags & $past(set_ev)) == $past(set_ev)))
      else $error("hardware event lost");
   reti_pop_a: assert property (
      (q.st == isc_pkg::ST_RUN && i_cmd.reti)
      |=> (q.sp == $past(q.sp) - isc_pkg::SP_STEP && o_mem_re) ##3 o_pc_load)
      else $error("return pop sequence broken");
   reti_gie_a: assert property (
      (q.st == isc_pkg::ST_POP3 && q.pop_pc) |=> o_gie && o_pc_load)
      else $error("return did not restore global enable");
   sleep_clock_a: assert property (
      (q.st == isc_pkg::ST_SLPL) |-> !o_sys_clk_en && o_osc_run)
      else $error("light sleep clock state wrong");
   deep_off_a: assert property (
      (q.st == isc_pkg::ST_SLPD) |-> !o_osc_run && !o_otp_on && !o_sys_clk_en)
      else $error("deep sleep still powered");
   deep_wake_a: assert property (
      (q.st == isc_pkg::ST_SLPD && n.st != isc_pkg::ST_SLPD) |-> wake_d)
      else $error("deep sleep left without pin toggle");
   cmp_wake_a: assert property (
      (q.st == isc_pkg::ST_SLPL && n.st == isc_pkg::ST_WAKE && !(|tog) && !(|i_tmr.match))
      |-> (i_cmp_en && i_cmp_wake_en))
      else $error("comparator wake without enables");
   wake_bound_a: assert property (
      (q.st == isc_pkg::ST_WAKE) |-> (q.wcnt <= WCNT_LAST))
      else $error("wake counter overran");

   // A set event in the same cycle is allowed to survive the clear.
   flag_clear_a: assert property (
      (i_wr && i_addr == isc_pkg::A_IRQ_FLAG) |=> ((q.flags & ~$past(i_wdata) & ~$past(set_ev)) == 8'h00))
      else $error("flag not cleared by write");
   enable_block_a: assert property (
      (q.st == isc_pkg::ST_RUN && !(|(q.flags & q.en))) |=> q.st != isc_pkg::ST_ENT)
      else $error("entry from a disabled source");
   timer_sleep_a: assert property (
      q.st == isc_pkg::ST_SLPL |-> o_tmr_run == (~$past(i_tmr.clk_is_sys) & $past(i_tmr.osc_on)))
      else $error("timer run state wrong in light sleep");
   busy_entry_a: assert property (
      q.st == isc_pkg::ST_ENT |-> o_busy ##1 !o_busy)
      else $error("busy flag wrong during entry");

   entry_c: cover property (q.st == isc_pkg::ST_ENT ##1 o_pc_load);
   push_c: cover property (q.st == isc_pkg::ST_PAF ##1 q.st == isc_pkg::ST_RUN);
   reti_c: cover property (q.st == isc_pkg::ST_POP3 && q.pop_pc);
   light_wake_c: cover property (q.st == isc_pkg::ST_SLPL ##1 q.st == isc_pkg::ST_WAKE);
   deep_wake_c: cover property (q.st == isc_pkg::ST_SLPD ##1 q.st == isc_pkg::ST_WAKE);
endmodule
`default_nettype wire

// >>> logic/isc_pkg.sv
// Purpose: Shared constants and types of the interrupt and sleep controller.
// Assumes: 8-bit register port, 8-bit data memory, 16-bit program counter.
// Notes:   Register offsets are word indices on the plain register port.
`default_nettype none
package isc_pkg;
   localparam int unsigned N_SRC = 8;
   localparam int unsigned N_PIN = 8;
   localparam int unsigned N_TMR = 3;
   localparam int unsigned EXT_N = 2;
   localparam int unsigned WCNT_W = 20;
   // Register map.
   localparam logic [3:0] A_IRQ_EN = 4'h0;
   localparam logic [3:0] A_IRQ_FLAG = 4'h1;
   localparam logic [3:0] A_EDGE_LO = 4'h2;
   localparam logic [3:0] A_EDGE_HI = 4'h3;
   localparam logic [3:0] A_STACK = 4'h4;
   localparam logic [3:0] A_STATUS = 4'h5;
   localparam int unsigned ST_GIE_BIT = 0;
   localparam int unsigned ST_BUSY_BIT = 1;
   // Edge select codes, two bits per source; 2'b11 acts as both.
   localparam logic [1:0] EDGE_BOTH = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [15:0] IRQ_VECTOR = 16'h0010;
   localparam logic [7:0] SP_STEP = 8'h02;
   localparam logic [7:0] SP_HI_OFS = 8'h01;
   // Wake-up delay in slow oscillator periods, rounded up to system clocks.
   localparam longint unsigned SYS_CLK_HZ = 20_000_000;
   localparam longint unsigned SLOW_OSC_HZ = 60_000;
   localparam longint unsigned WAKE_SLOW_PERIODS = 3000;
   localparam int unsigned WAKE_CYCLES_DFLT =
      int'((WAKE_SLOW_PERIODS * SYS_CLK_HZ + SLOW_OSC_HZ - 1) / SLOW_OSC_HZ);
   typedef enum logic [3:0] {
      ST_RUN  = 4'h0,
      ST_ENT  = 4'h1,
      ST_PAF  = 4'h3,
      ST_POP1 = 4'h2,
      ST_POP2 = 4'h6,
      ST_POP3 = 4'h7,
      ST_SLPL = 4'h5,
      ST_SLPD = 4'h4,
      ST_WAKE = 4'hC
   } isc_state_e;
   typedef struct packed {
      logic gie_on;
      logic gie_off;
      logic reti;
      logic push_af;
      logic pop_af;
      logic sleep_light;
      logic sleep_deep;
   } isc_cmd_s;
   typedef struct packed {
      logic [N_TMR-1:0] clk_is_sys;
      logic [N_TMR-1:0] osc_on;
      logic [N_TMR-1:0] match;
   } isc_tmr_s;
   typedef struct packed {
      isc_state_e       st;
      logic [7:0]       en;
      logic [7:0]       flags;
      logic [15:0]      edges;
      logic [7:0]       sp;
      logic             gie;
      logic             busy;
      logic [7:0]       src_prev;
      logic [EXT_N-1:0] ext_s1;
      logic [EXT_N-1:0] ext_s2;
      logic [7:0]       pin_s1;
      logic [7:0]       pin_s2;
      logic [7:0]       pin_prev;
      logic [WCNT_W-1:0] wcnt;
      logic [15:0]      hold;
      logic             pop_pc;
      logic [7:0]       rdata;
      logic             mem_we;
      logic             mem_re;
      logic [7:0]       mem_addr;
      logic [7:0]       mem_wdata;
      logic             pc_load;
      logic             af_load;
      logic [15:0]      ld_value;
      logic             sys_clk_en;
      logic             osc_run;
      logic             otp_on;
      logic [N_TMR-1:0] tmr_run;
   } isc_ctl_s;
   localparam isc_ctl_s CTL_RST = '{st: ST_RUN, sys_clk_en: 1'b1, osc_run: 1'b1,
      otp_on: 1'b1, tmr_run: 3'h7, default: '0};
endpackage
`default_nettype wire

// >>> verification/isc_ctrl_tb_top.sv
// Purpose: Self-checking bench for flags, stacking, return and both sleep modes.
// Assumes: Core commands and register accesses are driven right after a rising edge.
// Notes:   The wake delay is shortened to WK cycles to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module isc_ctrl_tb_top;
   localparam int unsigned WK     = 8;
   localparam logic [6:0]  C_ON   = 7'h40;
   localparam logic [6:0]  C_OFF  = 7'h20;
   localparam logic [6:0]  C_RETI = 7'h10;
   localparam logic [6:0]  C_PUSH = 7'h08;
   localparam logic [6:0]  C_POP  = 7'h04;
   localparam logic [6:0]  C_LS   = 7'h02;
   localparam logic [6:0]  C_DS   = 7'h01;
   logic              clk    = 1'b0;
   logic              rstn   = 1'b0;
   logic              wr     = 1'b0;
   logic              rd     = 1'b0;
   logic              bnd    = 1'b0;
   logic              cmp_en = 1'b0;
   logic              cmp_wk = 1'b0;
   logic              cmp_ev = 1'b0;
   logic [3:0]        addr   = 4'h0;
   logic [7:0]        wdata  = 8'h00;
   logic [7:0]        src    = 8'h00;
   logic [7:0]        pin    = 8'h00;
   logic [7:0]        pin_in = 8'hF0;
   logic [7:0]        die    = 8'hFF;
   isc_pkg::isc_cmd_s cmd    = '0;
   isc_pkg::isc_tmr_s tmr    = '0;
   logic              we, re, pc_ld, af_ld, busy, gie, sys_en, osc, otp;
   logic [7:0]        rdata, mrd, maddr, mwd, v;
   logic [15:0]       ldv;
   logic [2:0]        trun;
   int                num_errors = 0;
   int                n_compared = 0;
   int                we_cnt     = 0;
   int                n;

   initial forever #25 clk = ~clk;
   always @(posedge clk) if (we === 1'b1) we_cnt <= we_cnt + 1;

   isc_ctrl #(.WAKE_CYCLES(WK)) DUT (
      .i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_boundary(bnd), .i_cmd(cmd), .i_pc(16'hA5C3),
      .i_work_reg(8'h5A), .i_flag_reg(8'h96), .o_busy(busy), .o_pc_load(pc_ld), .o_af_load(af_ld),
      .o_ld_value(ldv), .o_gie(gie), .o_mem_we(we), .o_mem_re(re), .o_mem_addr(maddr),
      .o_mem_wdata(mwd), .i_mem_rdata(mrd), .i_irq_src(src), .i_pin(pin), .i_pin_is_input(pin_in),
      .i_digital_input_enable(die), .i_tmr(tmr), .i_cmp_en(cmp_en), .i_cmp_wake_en(cmp_wk),
      .i_cmp_event(cmp_ev), .o_sys_clk_en(sys_en), .o_osc_run(osc), .o_otp_on(otp), .o_tmr_run(trun));
   isc_mem_model partner (.i_sys_clk(clk), .i_we(we), .i_re(re), .i_addr(maddr), .i_wdata(mwd), .o_rdata(mrd));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(16'(rdata), 16'(e));
   endtask
   task automatic issue(input logic [6:0] c);
      @(posedge clk);
      cmd <= isc_pkg::isc_cmd_s'(c);
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask
   // Waits a bounded time; the caller then checks the signal, so a miss shows as a mismatch.
   task automatic wait_for(input int sel, output int cnt);
      for (cnt = 1; cnt < 60; cnt++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 && we === 1'b1) || (sel == 1 && pc_ld === 1'b1) ||
             (sel == 2 && af_ld === 1'b1) || (sel == 3 && sys_en === 1'b1)) break;
      end
   endtask
   task automatic poke(input logic [2:0] m, input logic c, input logic [7:0] p);
      @(posedge clk);
      tmr.match <= m;
      cmp_ev    <= c;
      pin       <= pin ^ p;
      @(posedge clk);
      tmr.match <= 3'h0;
      cmp_ev    <= 1'b0;
      wait_for(3, n);
   endtask
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #200_000;
      num_errors++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk(16'({sys_en, osc, otp, trun}), 16'h003F);
      rd_chk(isc_pkg::A_IRQ_EN, 8'h00);
      rd_chk(isc_pkg::A_STATUS, 8'h00);
      @(posedge clk);
      src <= 8'hFF;
      repeat (4) @(posedge clk);
      rd_chk(isc_pkg::A_IRQ_FLAG, 8'hFF);
      wr_reg(isc_pkg::A_IRQ_FLAG, 8'hF0);
      rd_chk(isc_pkg::A_IRQ_FLAG, 8'hF0);
      wr_reg(isc_pkg::A_IRQ_FLAG, 8'h00);
      wr_reg(isc_pkg::A_IRQ_FLAG, 8'hFF);
      rd_chk(isc_pkg::A_IRQ_FLAG, 8'h00);
      @(posedge clk);
      src <= 8'h00;
      repeat (4) @(posedge clk);
      rd_chk(isc_pkg::A_IRQ_FLAG, 8'hFF);
      wr_reg(isc_pkg::A_IRQ_FLAG, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr_reg(isc_pkg::A_EDGE_LO, 8'(c << 6));
         src[3] <= 1'b1;
         repeat (3) @(posedge clk);
         rd_chk(isc_pkg::A_IRQ_FLAG, (c == 2) ? 8'h00 : 8'h08);
         wr_reg(isc_pkg::A_IRQ_FLAG, 8'h00);
         src[3] <= 1'b0;
         repeat (3) @(posedge clk);
         rd_chk(isc_pkg::A_IRQ_FLAG, (c == 1) ? 8'h00 : 8'h08);
         wr_reg(isc_pkg::A_IRQ_FLAG, 8'h00);
      end
      $display("Test flags and edges done");
      wr_reg(isc_pkg::A_STACK, 8'h20);
      wr_reg(isc_pkg::A_IRQ_EN, 8'h04);
      rd_chk(isc_pkg::A_IRQ_EN, 8'h04);
      @(posedge clk);
      src[2] <= 1'b1;
      bnd    <= 1'b1;
      repeat (6) @(posedge clk);
      chk(16'(we_cnt), 16'h0000);
      bnd <= 1'b0;
      issue(C_ON);
      repeat (4) @(posedge clk);
      chk(16'(we_cnt), 16'h0000);
      rd_chk(isc_pkg::A_STATUS, 8'h01);
      @(posedge clk);
      bnd <= 1'b1;
      wait_for(0, n);
      chk({maddr, mwd}, 16'h20C3);
      chk(16'({we, gie}), 16'h0002);
      chk(16'(busy), 16'h0001);
      @(posedge clk);
      #1;
      chk({maddr, mwd}, 16'h21A5);
      chk(16'({we, pc_ld}), 16'h0003);
      chk(ldv, 16'h0010);
      rd_chk(isc_pkg::A_STACK, 8'h22);
      rd_chk(isc_pkg::A_STATUS, 8'h00);
      chk(16'(we_cnt), 16'h0002);
      issue(C_PUSH);
      chk({maddr, mwd}, 16'h225A);
      @(posedge clk);
      #1;
      chk({maddr, mwd}, 16'h2396);
      wr_reg(isc_pkg::A_IRQ_FLAG, 8'h00);
      issue(C_POP);
      chk(16'({busy, re, maddr}), 16'h0322);
      wait_for(2, n);
      chk(ldv, 16'h965A);
      rd_chk(isc_pkg::A_STACK, 8'h22);
      issue(C_RETI);
      chk(16'({busy, re, maddr}), 16'h0320);
      wait_for(1, n);
      chk(ldv, 16'hA5C3);
      rd_chk(isc_pkg::A_STACK, 8'h20);
      rd_chk(isc_pkg::A_STATUS, 8'h01);
      issue(C_OFF);
      rd_chk(isc_pkg::A_STATUS, 8'h00);
      $display("Test entry and return done");
      @(posedge clk);
      tmr.clk_is_sys <= 3'h1;
      tmr.osc_on     <= 3'h3;
      cmp_en         <= 1'b1;
      // No watchdog runs in this bench, so sleep is always entered with it stopped.
      issue(C_LS);
      chk(16'({sys_en, osc, otp, trun}), 16'h0012);
      poke(3'h1, 1'b1, 8'h04);
      chk(16'(sys_en), 16'h0000);
      @(posedge clk);
      cmp_wk <= 1'b1;
      poke(3'h0, 1'b1, 8'h00);
      chk(16'(n >= WK && n <= WK + 6), 16'h0001);
      issue(C_LS);
      poke(3'h2, 1'b0, 8'h00);
      chk(16'(sys_en), 16'h0001);
      issue(C_LS);
      poke(3'h0, 1'b0, 8'h10);
      chk(16'(sys_en), 16'h0001);
      $display("Test light sleep done");
      issue(C_DS);
      chk(16'({sys_en, osc, otp, trun}), 16'h0000);
      @(posedge clk);
      die <= 8'h0F;
      poke(3'h2, 1'b1, 8'h20);
      chk(16'(sys_en), 16'h0000);
      poke(3'h0, 1'b0, 8'h02);
      chk(16'({sys_en, osc, otp}), 16'h0007);
      rd_chk(isc_pkg::A_STACK, 8'h20);
      rd_chk(isc_pkg::A_IRQ_EN, 8'h04);
      $display("Test deep sleep done");
      stop_test();
   end
endmodule
`default_nettype wire

// >>> verification/isc_mem_model.sv
// Purpose: Stack memory model facing the controller's stack port.
// Assumes: A read returns its data in the cycle after the read strobe.
// Notes:   Outside a read answer the data bus shows inverted junk, never a held value.
`timescale 1ns/1ps
`default_nettype none
module isc_mem_model (
   // Clock.
   input  wire logic       i_sys_clk,
   // Stack port.
   input  wire logic       i_we,
   input  wire logic       i_re,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [256];
   initial o_rdata = 8'h00;
   // The stack is plain data memory at whatever the pointer names.
   always @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      // Flipping the bus between answers stops a stale byte from passing as fresh data.
      if (i_re) begin
         o_rdata <= mem[i_addr];
      end else begin
         o_rdata <= ~o_rdata;
      end
   end
endmodule
`default_nettype wire
